//--- verilog/event_delay_pkg.sv
package event_delay_pkg;
  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int CNT_W = 35;
  localparam int LANES = 5;
  localparam int ADDR_W = 16;
  localparam int PRE_W = 16;
  localparam int STEP_W = 9;
  // ---------------------------------------------------------------
  // Byte bus locations
  // ---------------------------------------------------------------
  localparam logic [15:0] ADR_LAT_BASE = 16'h0000;
  localparam logic [15:0] ADR_STATUS = 16'h0005;
  localparam logic [15:0] ADR_CTRL = 16'h0006;
  localparam logic [15:0] ADR_PRE_LO = 16'h0008;
  localparam logic [15:0] ADR_PRE_HI = 16'h0009;
  localparam logic [15:0] ADR_SYS_STEP = 16'h4884;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_HOLD = 0;
  localparam int CTRL_DIAG_EVT = 1;
  localparam int CTRL_FAST = 2;
  localparam int CTRL_RESTART_N = 3;
  localparam int STAT_TC = 0;
  localparam int STAT_PRE_LEVEL = 1;
  localparam int STAT_HOLD = 2;
  localparam int STAT_ARMED = 3;
  // ---------------------------------------------------------------
  // Reset and pattern values
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h07;
  localparam logic [7:0] LATCH_RST = 8'hff;
  localparam logic [34:0] CNT_RST = 35'h7_ffff_ffff;
  localparam logic [15:0] PRE_RST = 16'hffff;
  localparam logic [15:0] PRE_LAUNCH = 16'h0000;
  localparam logic [15:0] PRE_IDLE = 16'hffff;
  localparam logic [34:0] WALK_START = 35'h4_0000_0000;
  localparam logic [34:0] WALK_LAST = 35'h0_0000_0001;
  // ---------------------------------------------------------------
  // Step counts
  // ---------------------------------------------------------------
  localparam logic [8:0] PRE_RISE_STEPS = 9'h100;
  localparam logic [8:0] PRE_FALL_STEPS = 9'h002;
  localparam logic [1:0] EVT_FAST_STEPS = 2'h2;
  localparam logic [8:0] DIS_FAST_FIRST = 9'h004;
  localparam logic [8:0] DIS_FAST_LATER = 9'h003;
endpackage

//--- verilog/event_delay_bus_if.sv
`timescale 1ns/1ps
interface event_delay_bus_if;
  import event_delay_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  modport device (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

//--- verilog/pretrigger_generator.sv
`timescale 1ns/1ps
module pretrigger_generator (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic sys_step_i,
  input wire logic wr_lo_i,
  input wire logic wr_hi_i,
  input wire logic [7:0] wdata_i,
  output logic [event_delay_pkg::PRE_W-1:0] window_c_counter_o,
  output logic pretrigger_launch_o,
  output logic pretrigger_terminal_count_o
);
  import event_delay_pkg::*;

  logic [7:0] lo_hold_r;
  logic [PRE_W-1:0] window_c_counter_r;
  logic pre_level_r;
  logic [8:0] settle_r;

  // ---------------------------------------------------------------
  // Launch and randomizer settling
  // ---------------------------------------------------------------
  wire launch = (window_c_counter_r == PRE_LAUNCH);
  wire [8:0] settle_target = launch ? PRE_RISE_STEPS : PRE_FALL_STEPS;
  wire [8:0] settle_inc = settle_r + 9'h001;
  wire settled = (launch != pre_level_r) && (settle_inc == settle_target);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lo_hold_r <= 8'h00;
      window_c_counter_r <= PRE_RST;
    end else begin
      if (wr_lo_i) begin
        lo_hold_r <= wdata_i;
      end
      if (wr_hi_i) begin
        window_c_counter_r <= {wdata_i, lo_hold_r};
      end else if (sys_step_i && !launch) begin
        window_c_counter_r <= window_c_counter_r - 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_level_r <= 1'b0;
      settle_r <= 9'h000;
    end else if (sys_step_i) begin
      if (launch == pre_level_r) begin
        settle_r <= 9'h000;
      end else if (settled) begin
        pre_level_r <= launch;
        settle_r <= 9'h000;
      end else begin
        settle_r <= settle_inc;
      end
    end
  end

  assign window_c_counter_o = window_c_counter_r;
  assign pretrigger_launch_o = launch;
  assign pretrigger_terminal_count_o = pre_level_r;
endmodule // pretrigger_generator

//--- verilog/event_delay_down_counter.sv
// What this block does
// - 35-bit counter counting downward
// - Latches written bytewise, five bytes, LSB first
// - Reads return bytes LSB first, top bits read as ones
// - Read value is ones complement of contents
// - At zero, read shows inverse of last load
// - Event pulse with load off decrements by one
// - Nonzero load clears terminal-count bit
// - Decrement after power-of-two load sets terminal count
// - Loading zero sets terminal count, reads inverse zero
// - Latches reach counter only on clocked load
// - Controller toggles pretrigger signal to clock load
// - Pretrigger: zero+256 steps high, FFFF+two steps low
// - Disable load: clear, fast step, pretrigger, 4/3 steps
// - Event: diag bit low-high, two fast steps
// - Walking ones from top bit down to one
// - Access to 4884 single-steps system clocks
// - Fast clock stepped by control bit low-high
// - Diagnostic entry loads all ones, terminal counts low
// - Restart held low forces counter loads
// - Checker reports count and content errors by phase
// - Re-enable: holdoff load high, then pretrigger low
`timescale 1ns/1ps
module event_delay_down_counter (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  event_delay_bus_if.device bus,
  output logic [event_delay_pkg::CNT_W-1:0] count_o,
  output logic terminal_count_o,
  output logic pretrigger_terminal_count_o,
  output logic event_count_clock_o,
  output logic main_holdoff_load_n_o
);
  import event_delay_pkg::*;

  function automatic logic at(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] loc);
    at = (a == loc);
  endfunction

  logic [7:0] latch_r [LANES];
  logic [7:0] ctrl_r;
  logic [7:0] rdata_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] last_load_r;
  logic tc_r;
  logic hold_gate_r;
  logic pre_level_prev_r;
  logic evt_arm_r;
  logic [1:0] evt_steps_r;
  logic evt_pulse_r;
  logic pre_level;
  logic [PRE_W-1:0] pre_cnt;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire access = bus.wr | bus.rd;
  wire sys_step = access & at(bus.addr, ADR_SYS_STEP);
  wire ctrl_wr = bus.wr & at(bus.addr, ADR_CTRL);
  wire pre_lo_wr = bus.wr & at(bus.addr, ADR_PRE_LO);
  wire pre_hi_wr = bus.wr & at(bus.addr, ADR_PRE_HI);
  wire [ADDR_W-1:0] lane_off = bus.addr - ADR_LAT_BASE;
  wire lane_hit = (lane_off < ADDR_W'(LANES));

  // ---------------------------------------------------------------
  // Control latch edges
  // ---------------------------------------------------------------
  wire fast_step = ctrl_wr & bus.wdata[CTRL_FAST] & ~ctrl_r[CTRL_FAST];
  wire diag_rise = ctrl_wr & bus.wdata[CTRL_DIAG_EVT] & ~ctrl_r[CTRL_DIAG_EVT];
  wire hold_set = ctrl_wr & bus.wdata[CTRL_HOLD];
  wire hold_clr = fast_step & ~ctrl_r[CTRL_HOLD];
  wire restart_low = ~ctrl_r[CTRL_RESTART_N];

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_r <= bus.wdata;
    end
  end

  // ---------------------------------------------------------------
  // Input latches
  // ---------------------------------------------------------------
  wire [8*LANES-1:0] latch_bytes;

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    wire lane_wr = bus.wr & at(bus.addr, ADR_LAT_BASE + ADDR_W'(g));
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        latch_r[g] <= LATCH_RST;
      end else if (lane_wr) begin
        latch_r[g] <= bus.wdata;
      end
    end
    assign latch_bytes[8*g +: 8] = latch_r[g];
  end

  wire [CNT_W-1:0] latch_word = latch_bytes[CNT_W-1:0];

  // ---------------------------------------------------------------
  // Pretrigger generator
  // ---------------------------------------------------------------
  pretrigger_generator u_pretrigger (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .sys_step_i(sys_step),
    .wr_lo_i(pre_lo_wr),
    .wr_hi_i(pre_hi_wr),
    .wdata_i(bus.wdata),
    .window_c_counter_o(pre_cnt),
    .pretrigger_launch_o(),
    .pretrigger_terminal_count_o(pre_level)
  );

  wire pre_rise = pre_level & ~pre_level_prev_r;

  // ---------------------------------------------------------------
  // Holdoff load gate
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_gate_r <= 1'b1;
      pre_level_prev_r <= 1'b0;
    end else begin
      pre_level_prev_r <= pre_level;
      if (hold_set) begin
        hold_gate_r <= 1'b1;
      end else if (hold_clr) begin
        hold_gate_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Event clock path
  // ---------------------------------------------------------------
  wire [1:0] evt_steps_inc = evt_steps_r + 2'h1;
  wire evt_fire = evt_arm_r & fast_step & (evt_steps_inc == EVT_FAST_STEPS);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      evt_arm_r <= 1'b0;
      evt_steps_r <= 2'h0;
      evt_pulse_r <= 1'b0;
    end else begin
      evt_pulse_r <= evt_fire;
      if (diag_rise) begin
        evt_arm_r <= 1'b1;
        evt_steps_r <= 2'h0;
      end else if (evt_fire) begin
        evt_arm_r <= 1'b0;
        evt_steps_r <= 2'h0;
      end else if (evt_arm_r && fast_step) begin
        evt_steps_r <= evt_steps_inc;
      end
    end
  end

  // ---------------------------------------------------------------
  // Down counter
  // ---------------------------------------------------------------
  wire load_now = (pre_rise & hold_gate_r) | (sys_step & restart_low);
  wire count_ev = evt_pulse_r & ~hold_gate_r;
  wire cnt_zero = (cnt_r == '0);
  wire dec_now = count_ev & ~cnt_zero & ~load_now;
  wire [CNT_W-1:0] cnt_dec = cnt_r - CNT_W'(1);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= CNT_RST;
      last_load_r <= CNT_RST;
      tc_r <= 1'b0;
    end else if (load_now) begin
      cnt_r <= latch_word;
      last_load_r <= latch_word;
      tc_r <= (latch_word == '0) | count_ev;
    end else begin
      if (dec_now) begin
        cnt_r <= cnt_dec;
      end
      if (count_ev) begin
        tc_r <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  wire stuck_zero = cnt_zero & (last_load_r != '0);
  wire [CNT_W-1:0] shown = stuck_zero ? last_load_r : cnt_r;
  wire [8*LANES-1:0] inv_word = ~{5'h00, shown};
  wire [8*LANES-1:0] inv_shift = inv_word >> {lane_off[2:0], 3'h0};
  wire [7:0] status_byte = {4'h0, evt_arm_r, hold_gate_r, pre_level, tc_r};
  wire [7:0] rd_mux =
    lane_hit ? inv_shift[7:0] :
    at(bus.addr, ADR_STATUS) ? status_byte :
    at(bus.addr, ADR_CTRL) ? ctrl_r :
    at(bus.addr, ADR_PRE_LO) ? pre_cnt[7:0] :
    at(bus.addr, ADR_PRE_HI) ? pre_cnt[15:8] :
    8'h00;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= 8'h00;
    end else if (bus.rd) begin
      rdata_r <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign bus.rdata = rdata_r;
  assign count_o = cnt_r;
  assign terminal_count_o = tc_r;
  assign pretrigger_terminal_count_o = pre_level;
  assign event_count_clock_o = evt_pulse_r;
  assign main_holdoff_load_n_o = ~hold_gate_r;
endmodule // event_delay_down_counter

//--- verilog/event_delay_diag_host.sv
`timescale 1ns/1ps
module event_delay_diag_host (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  event_delay_bus_if.host bus,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o,
  output logic fail_o,
  output logic err_valid_o,
  output logic [3:0] err_code_o
);
  import event_delay_pkg::*;

  typedef enum {H_IDLE, H_ISSUE, H_WAIT, H_CAPT, H_DONE} hstate_t;
  typedef enum {OP_CTRL, OP_WRLAT, OP_PRE0, OP_PREFF, OP_SYS_HI, OP_SYS_LO, OP_FAST1,
                OP_FASTN, OP_EVT, OP_FAST2, OP_CHKTC, OP_CHKCNT} op_t;

  function automatic op_t op_of(input logic [4:0] s);
    case (s)
      5'd0, 5'd6, 5'd17: op_of = OP_CTRL;
      5'd1: op_of = OP_WRLAT;
      5'd2, 5'd8: op_of = OP_PRE0;
      5'd3, 5'd9: op_of = OP_SYS_HI;
      5'd4, 5'd18: op_of = OP_PREFF;
      5'd5, 5'd19: op_of = OP_SYS_LO;
      5'd7: op_of = OP_FAST1;
      5'd10: op_of = OP_FASTN;
      5'd13: op_of = OP_EVT;
      5'd14: op_of = OP_FAST2;
      5'd11, 5'd15, 5'd20: op_of = OP_CHKTC;
      default: op_of = OP_CHKCNT;
    endcase
  endfunction

  function automatic logic [7:0] ctrl_byte(input logic hold, input logic diag, input logic fast);
    ctrl_byte = 8'h00;
    ctrl_byte[CTRL_RESTART_N] = 1'b1;
    ctrl_byte[CTRL_FAST] = fast;
    ctrl_byte[CTRL_DIAG_EVT] = diag;
    ctrl_byte[CTRL_HOLD] = hold;
  endfunction

  hstate_t state_r;
  logic [4:0] step_r;
  logic [STEP_W-1:0] sub_r;
  logic [CNT_W-1:0] pat_r;
  logic first_r;
  logic zero_r;
  logic hold_r;
  logic [8*LANES-1:0] acc_r;
  logic [ADDR_W-1:0] addr_r;
  logic [7:0] wdata_r;
  logic wr_r;
  logic rd_r;
  logic fail_r;
  logic err_valid_r;
  logic [3:0] err_code_r;

  // ---------------------------------------------------------------
  // Current access
  // ---------------------------------------------------------------
  op_t op;
  logic [STEP_W-1:0] len;
  logic [ADDR_W-1:0] acc_addr;
  logic [7:0] acc_data;
  logic acc_rd;
  wire hold_val = (step_r != 5'd6);
  wire [8*LANES-1:0] pat_bytes = {5'h00, pat_r} >> {sub_r[2:0], 3'h0};
  wire [15:0] pre_val = (op == OP_PRE0) ? PRE_LAUNCH : PRE_IDLE;
  wire [ADDR_W-1:0] lane_addr = ADR_LAT_BASE + ADDR_W'(sub_r);

  assign op = op_of(step_r);

  always_comb begin
    len = STEP_W'(1);
    acc_addr = ADR_CTRL;
    acc_data = ctrl_byte(hold_r, 1'b1, 1'b1);
    acc_rd = 1'b0;
    case (op)
      OP_CTRL: acc_data = ctrl_byte(hold_val, 1'b1, 1'b1);
      OP_WRLAT: begin
        len = STEP_W'(LANES);
        acc_addr = lane_addr;
        acc_data = pat_bytes[7:0];
      end
      OP_PRE0, OP_PREFF: begin
        len = STEP_W'(2);
        acc_addr = sub_r[0] ? ADR_PRE_HI : ADR_PRE_LO;
        acc_data = sub_r[0] ? pre_val[15:8] : pre_val[7:0];
      end
      OP_SYS_HI, OP_SYS_LO: begin
        len = (op == OP_SYS_HI) ? PRE_RISE_STEPS : PRE_FALL_STEPS;
        acc_addr = ADR_SYS_STEP;
        acc_data = 8'h00;
      end
      OP_FAST1, OP_FASTN, OP_FAST2: begin
        len = (op == OP_FAST1) ? STEP_W'(2) :
              (op == OP_FAST2) ? STEP_W'(4) :
              first_r ? {DIS_FAST_FIRST[7:0], 1'b0} : {DIS_FAST_LATER[7:0], 1'b0};
        acc_data = ctrl_byte(hold_r, 1'b1, sub_r[0]);
      end
      OP_EVT: begin
        len = STEP_W'(2);
        acc_data = ctrl_byte(hold_r, sub_r[0], 1'b1);
      end
      OP_CHKTC: begin
        acc_addr = ADR_STATUS;
        acc_rd = 1'b1;
      end
      OP_CHKCNT: begin
        len = STEP_W'(LANES);
        acc_addr = lane_addr;
        acc_rd = 1'b1;
      end
      default: len = STEP_W'(1);
    endcase
  end

  // ---------------------------------------------------------------
  // Checking
  // ---------------------------------------------------------------
  wire [1:0] phase = (step_r < 5'd13) ? 2'd0 : (step_r < 5'd20) ? 2'd1 : 2'd2;
  wire exp_tc = (phase != 2'd0);
  wire [CNT_W-1:0] after_dec = (pat_r == WALK_LAST) ? pat_r : pat_r - CNT_W'(1);
  wire [CNT_W-1:0] exp_cnt = (phase == 2'd0) ? ~pat_r :
                             (phase == 2'd1) ? ~after_dec : '1;
  wire [8*LANES-1:0] acc_nxt = {bus.rdata, acc_r[8*LANES-1:8]};
  wire [CNT_W-1:0] diff = acc_nxt[CNT_W-1:0] ^ exp_cnt;
  wire last_sub = (sub_r == len - STEP_W'(1));
  wire tc_bad = (op == OP_CHKTC) & (bus.rdata[STAT_TC] != exp_tc);
  wire cnt_bad = (op == OP_CHKCNT) & last_sub & (diff != '0);
  wire [1:0] field = (diff[34:32] != 3'h0) ? 2'd1 : (diff[31:16] != 16'h0000) ? 2'd2 : 2'd3;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= H_IDLE;
      step_r <= 5'd0;
      sub_r <= '0;
      pat_r <= WALK_START;
      first_r <= 1'b1;
      zero_r <= 1'b0;
      hold_r <= 1'b1;
      acc_r <= '0;
      addr_r <= '0;
      wdata_r <= 8'h00;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      fail_r <= 1'b0;
      err_valid_r <= 1'b0;
      err_code_r <= 4'h0;
    end else begin
      err_valid_r <= 1'b0;
      case (state_r)
        H_IDLE, H_DONE: begin
          if (start_i) begin
            state_r <= H_ISSUE;
            step_r <= 5'd0;
            sub_r <= '0;
            pat_r <= WALK_START;
            first_r <= 1'b1;
            zero_r <= 1'b0;
            hold_r <= 1'b1;
            fail_r <= 1'b0;
          end
        end
        H_ISSUE: begin
          addr_r <= acc_addr;
          wdata_r <= acc_data;
          wr_r <= ~acc_rd;
          rd_r <= acc_rd;
          state_r <= H_WAIT;
        end
        H_WAIT: begin
          wr_r <= 1'b0;
          rd_r <= 1'b0;
          state_r <= H_CAPT;
        end
        H_CAPT: begin
          state_r <= H_ISSUE;
          acc_r <= acc_nxt;
          if (tc_bad | cnt_bad) begin
            fail_r <= 1'b1;
            err_valid_r <= 1'b1;
            err_code_r <= {phase, tc_bad ? 2'd0 : field};
          end
          if (!last_sub) begin
            sub_r <= sub_r + STEP_W'(1);
          end else begin
            sub_r <= '0;
            if (op == OP_CTRL) begin
              hold_r <= hold_val;
            end
            if (zero_r && step_r == 5'd5) begin
              step_r <= 5'd20;
            end else if (step_r == 5'd19) begin
              step_r <= 5'd1;
              first_r <= 1'b0;
              zero_r <= (pat_r == WALK_LAST);
              pat_r <= pat_r >> 1;
            end else if (step_r == 5'd21) begin
              state_r <= H_DONE;
            end else begin
              step_r <= step_r + 5'd1;
            end
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;
  assign bus.wr = wr_r;
  assign bus.rd = rd_r;
  assign busy_o = (state_r == H_ISSUE) | (state_r == H_WAIT) | (state_r == H_CAPT);
  assign done_o = (state_r == H_DONE);
  assign fail_o = fail_r;
  assign err_valid_o = err_valid_r;
  assign err_code_o = err_code_r;
endmodule // event_delay_diag_host

//--- sim/event_delay_down_counter_monitor.sv
`timescale 1ns/1ps
module event_delay_down_counter_monitor (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [event_delay_pkg::ADDR_W-1:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [event_delay_pkg::CNT_W-1:0] count_o,
  input wire logic terminal_count_o,
  input wire logic pretrigger_terminal_count_o,
  input wire logic event_count_clock_o,
  input wire logic main_holdoff_load_n_o
);
  import event_delay_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  wire step_w = (wr || rd) && (addr == ADR_SYS_STEP);
  wire evt_w = event_count_clock_o && main_holdoff_load_n_o;
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_wr_pulse;
    wr |=> !wr;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe longer than one cycle");
  property p_rdata_hold;
    !rd |=> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");
  property p_read_inverse;
    rd && addr == ADR_LAT_BASE && count_o != '0 |=> rdata == ~$past(count_o[7:0]);
  endproperty
  a_read_inverse: assert property (p_read_inverse)
    else $error("low byte read not inverted contents");
  property p_top_bits;
    rd && addr == ADR_LAT_BASE + 16'h0004 |=> rdata[7:3] == 5'h1f;
  endproperty
  a_top_bits: assert property (p_top_bits)
    else $error("top byte unused bits not set");
  property p_status_tc;
    rd && addr == ADR_STATUS |=> rdata[STAT_TC] == $past(terminal_count_o);
  endproperty
  a_status_tc: assert property (p_status_tc)
    else $error("status bit differs from terminal count");
  property p_pre_step;
    $changed(pretrigger_terminal_count_o) |-> $past(step_w);
  endproperty
  a_pre_step: assert property (p_pre_step)
    else $error("pretrigger moved without a system step");
  property p_event_tc;
    evt_w |-> ##[0:2] terminal_count_o;
  endproperty
  a_event_tc: assert property (p_event_tc)
    else $error("terminal count not set after count event");
  property p_event_dec;
    evt_w && count_o != '0 |=> count_o == $past(count_o) - CNT_W'(1);
  endproperty
  a_event_dec: assert property (p_event_dec)
    else $error("count event did not decrement by one");
endmodule // event_delay_down_counter_monitor

//--- sim/event_delay_down_counter_bench.sv
`timescale 1ns/1ps
module event_delay_down_counter_bench;
  import event_delay_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic start_i = 1'b0;
  logic [CNT_W-1:0] count_o;
  logic terminal_count_o, pretrigger_terminal_count_o, event_count_clock_o;
  logic main_holdoff_load_n_o, busy_o, done_o, fail_o, err_valid_o;
  logic [3:0] err_code_o;
  int errors = 0;
  int n_checks = 0;
  int n_lat = 0;
  int n_evt = 0;
  int n_err = 0;
  logic [15:0] lat_a [LANES];
  logic [7:0] lat_d [LANES];
  event_delay_bus_if bus ();
  event_delay_down_counter event_delay_down_counter_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .bus(bus.device), .count_o(count_o), .terminal_count_o(terminal_count_o),
    .pretrigger_terminal_count_o(pretrigger_terminal_count_o),
    .event_count_clock_o(event_count_clock_o), .main_holdoff_load_n_o(main_holdoff_load_n_o));
  event_delay_diag_host event_delay_diag_host_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .bus(bus.host), .start_i(start_i), .busy_o(busy_o), .done_o(done_o), .fail_o(fail_o),
    .err_valid_o(err_valid_o), .err_code_o(err_code_o));
  event_delay_down_counter_monitor event_delay_down_counter_monitor_i (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .addr(bus.addr), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata),
    .count_o(count_o), .terminal_count_o(terminal_count_o),
    .pretrigger_terminal_count_o(pretrigger_terminal_count_o),
    .event_count_clock_o(event_count_clock_o), .main_holdoff_load_n_o(main_holdoff_load_n_o));
  always #5 mclk_i = ~mclk_i;
  // ---------------------------------------------------------------
  // Wire watch
  // ---------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (bus.wr === 1'b1 && bus.addr < ADR_LAT_BASE + 16'h0005) begin
      if (n_lat < LANES) begin
        lat_a[n_lat] = bus.addr;
        lat_d[n_lat] = bus.wdata;
      end
      n_lat++;
    end
    if (event_count_clock_o === 1'b1) n_evt++;
    if (err_valid_o === 1'b1) n_err++;
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic pulse_start();
    @(negedge mclk_i) start_i = 1'b1;
    @(negedge mclk_i) start_i = 1'b0;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_state();
    check("count", 64'(count_o), 64'(CNT_RST));
    check("tc", 64'(terminal_count_o), 64'h0);
    check("pretrig", 64'(pretrigger_terminal_count_o), 64'h0);
    check("rdata", 64'(bus.rdata), 64'h0);
    check("busy", 64'(busy_o), 64'h0);
    check("holdoff", 64'(main_holdoff_load_n_o), 64'h0);
  endtask
  task automatic t_walk_run();
    int k;
    n_lat = 0;
    n_evt = 0;
    n_err = 0;
    pulse_start();
    check("busy", 64'(busy_o), 64'h1);
    repeat (20) @(negedge mclk_i);
    pulse_start();
    for (k = 0; k < 90000 && done_o !== 1'b1; k++) @(negedge mclk_i);
    check("done", 64'(done_o), 64'h1);
    check("fail", 64'(fail_o), 64'h0);
    check("errs", 64'(n_err), 64'h0);
    check("events", 64'(n_evt), 64'd35);
    check("err code", 64'(err_code_o), 64'h0);
    check("holdoff end", 64'(main_holdoff_load_n_o), 64'h0);
    check("latch writes", 64'(n_lat), 64'd180);
    for (k = 0; k < LANES; k++) begin
      check("lane addr", 64'(lat_a[k]), 64'(ADR_LAT_BASE + 16'(k)));
      check("lane data", 64'(lat_d[k]), 64'(8'(WALK_START >> (8 * k))));
    end
    check("final count", 64'(count_o), 64'h0);
    check("final tc", 64'(terminal_count_o), 64'h1);
  endtask
  task automatic t_restart_reset();
    pulse_start();
    check("busy again", 64'(busy_o), 64'h1);
    check("fail cleared", 64'(fail_o), 64'h0);
    repeat (50) @(negedge mclk_i);
    rst_n_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    t_reset_state();
    rst_n_i = 1'b1;
  endtask
  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(negedge mclk_i);
    t_reset_state();
    rst_n_i = 1'b1;
    @(negedge mclk_i);
    t_walk_run();
    t_restart_reset();
    repeat (5) @(negedge mclk_i);
    stop_test();
  end
  initial begin
    repeat (95000) @(posedge mclk_i);
    errors++;
    $display("Watchdog expired");
    stop_test();
  end
endmodule // event_delay_down_counter_bench
